/* logic/stx_consts.svh */
// Register offsets, field positions, reset values, status codes and timing
// counts of the two-wire slave transmitter. Definitions only.
`ifndef STX_CONSTS_SVH
`define STX_CONSTS_SVH

// APB byte offsets, one aligned 32-bit word per register
`define STX_OFF_ADDR      8'h00
`define STX_OFF_CTRL      8'h04
`define STX_OFF_STAT      8'h08
`define STX_OFF_DATA      8'h0C
`define STX_OFF_IRQ       8'h10
`define STX_OFF_MASK      8'h14
`define STX_OFF_MODE      8'h18

// Control register bit positions
`define STX_CTL_FLAG      7
`define STX_CTL_ACK       6
`define STX_CTL_START     5
`define STX_CTL_STOP      4
`define STX_CTL_EN        2
`define STX_CTL_WMASK     8'h74

// Own address register fields
`define STX_ADR_GCE       0
`define STX_GC_ADDR       7'h00

// Status codes, prescaler bits always zero
`define STX_CODE_ADDR_RD  8'hA8
`define STX_CODE_ARB_RD   8'hB0
`define STX_CODE_DATA_ACK 8'hB8
`define STX_CODE_NACK     8'hC0
`define STX_CODE_LAST_ACK 8'hC8
`define STX_CODE_NONE     8'hF8
`define STX_CODE_BUS_ERR  8'h00

// Interrupt status and mask bits
`define STX_IRQ_FLAG      0
`define STX_IRQ_BERR      1
`define STX_IRQ_WAKE      2
`define STX_IRQ_W         3

// Mode register bits
`define STX_MODE_SLEEP    0
`define STX_MODE_TX       1
`define STX_MODE_RX       2
`define STX_MODE_WAKE     3

// Reset values
`define STX_RST_ADDR      8'h00
`define STX_RST_CTRL      8'h00
`define STX_RST_DATA      8'hFF

// Timing
`define STX_CLK_PERIOD_PS 5000
`define STX_START_HOLD_NS 4000
`define STX_START_HOLD_CYC \
  ((`STX_START_HOLD_NS * 1000 + `STX_CLK_PERIOD_PS - 1) / `STX_CLK_PERIOD_PS)

`endif

/* logic/stx_pkg.sv */
// Types shared by the two-wire slave transmitter design files.
// Constants live in stx_consts.svh.
package stx_pkg;

  typedef enum logic [2:0] {
    STX_IDLE     = 3'b000,
    STX_ADDR     = 3'b001,
    STX_ADDR_ACK = 3'b010,
    STX_TX       = 3'b011,
    STX_TX_ACK   = 3'b100,
    STX_HOLD     = 3'b101,
    STX_IGNORE   = 3'b110,
    STX_GEN      = 3'b111
  } stx_state_type;

endpackage

/* logic/stx_sync.sv */
// Three-stage input synchroniser with agreement filter for a bus pin.
// Assumes the pin idles high; the output follows once stages two and
// three agree.
`timescale 1ns/1ps

module stx_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and filtered level
  input  wire logic pin,
  output logic      level
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      s3    <= 1'b1;
      level <= 1'b1;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

endmodule

/* logic/stx_top.sv */
// Slave transmitter of a byte-oriented two-wire serial interface, with
// APB registers, interrupt status/mask and a deep-sleep wake request.
// Assumes the bus pins are open drain with external pull-ups and that
// arb_lost comes from master logic on the same clock.
//
// Function
// - Answer only own seven-bit address in bits 7:1.
// - General call answered only when its enable set.
// - Read bit enters transmitter, write bit receiver.
// - Own address read acknowledged: flag, code A8.
// - After lost arbitration, address read gives B0.
// - Byte sent; ack enable low marks it last.
// - Acked data byte: flag, code B8.
// - Nack gives C0, then not-addressed slave.
// - Start request at C0/C8 sends START when free.
// - Acked last byte gives C8, master reads ones.
// - Ack enable low ignores address, still monitors.
// - Deep sleep match wakes chip, holds clock low.
// - Data register skips address byte in sleep.
// - Code F8 whenever flag is clear.
// - Misplaced START/STOP: code 00, recover by stop.
`timescale 1ns/1ps
`include "stx_consts.svh"

module stx_top (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Two-wire bus pins, enable high while pulling low
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // System side
  input  wire logic        arb_lost,
  output logic             irq,
  output logic             wake_req,
  output logic             start_sent
);

  localparam logic [9:0] HOLD_CYC = 10'(`STX_START_HOLD_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus condition detection

  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;

  stx_sync u_scl_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (scl_i),
    .level   (scl_f)
  );

  stx_sync u_sda_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (sda_i),
    .level   (sda_f)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  wire scl_rise  = scl_f & ~scl_q;
  wire scl_fall  = ~scl_f & scl_q;
  wire start_det = scl_f & scl_q & sda_q & ~sda_f;
  wire stop_det  = scl_f & scl_q & ~sda_q & sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  stx_pkg::stx_state_type state;
  logic [7:0]             own_slave_address;
  logic [7:0]             bus_control_register;
  logic [7:0]             bus_data_register;
  logic [7:0]             status_code;
  logic                   interrupt_flag;
  logic [`STX_IRQ_W-1:0]  irq_pend;
  logic [`STX_IRQ_W-1:0]  irq_mask;
  logic                   deep_sleep;
  logic                   tx_mode;
  logic                   rx_mode;
  logic [7:0]             shreg;
  logic [3:0]             bit_cnt;
  logic                   last_byte;
  logic                   master_ack;
  logic                   arb_pend;
  logic                   busy;
  logic                   start_pend;
  logic [9:0]             gen_cnt;
  logic                   hw_stop_clr;
  logic                   hw_start_clr;
  logic                   flag_q;
  logic                   wake_q;

  wire interface_enable   = bus_control_register[`STX_CTL_EN];
  wire acknowledge_enable = bus_control_register[`STX_CTL_ACK];
  wire start_request      = bus_control_register[`STX_CTL_START];
  wire stop_request       = bus_control_register[`STX_CTL_STOP];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire       setup    = psel & ~penable;
  wire       acc      = psel & penable & pready;
  wire       wr_acc   = acc & pwrite;
  wire       rd_acc   = acc & ~pwrite;
  wire       sel_addr = paddr == `STX_OFF_ADDR;
  wire       sel_ctrl = paddr == `STX_OFF_CTRL;
  wire       sel_stat = paddr == `STX_OFF_STAT;
  wire       sel_data = paddr == `STX_OFF_DATA;
  wire       sel_irq  = paddr == `STX_OFF_IRQ;
  wire       sel_mask = paddr == `STX_OFF_MASK;
  wire       sel_mode = paddr == `STX_OFF_MODE;
  wire       sel_any  = sel_addr | sel_ctrl | sel_stat | sel_data |
                        sel_irq | sel_mask | sel_mode;
  wire       wr_ctrl  = wr_acc & sel_ctrl;
  wire       flag_clr = wr_ctrl & pwdata[`STX_CTL_FLAG];

  // Code F8 is shown whenever the flag is clear
  wire [7:0] stat_view = interrupt_flag ? status_code : `STX_CODE_NONE;
  wire [7:0] ctrl_view = {interrupt_flag, bus_control_register[6:0]};
  wire [3:0] mode_view = {wake_req, rx_mode, tx_mode, deep_sleep};

  wire [31:0] rd_mux =
    sel_addr ? {24'h000000, own_slave_address} :
    sel_ctrl ? {24'h000000, ctrl_view} :
    sel_stat ? {24'h000000, stat_view} :
    sel_data ? {24'h000000, bus_data_register} :
    sel_irq  ? {29'h00000000, irq_pend} :
    sel_mask ? {29'h00000000, irq_mask} :
    sel_mode ? {28'h0000000, mode_view} : 32'h00000000;

  // Read data is captured in the setup cycle, so a read clears only the
  // bits it actually returned and a later event is not lost.
  wire [`STX_IRQ_W-1:0] irq_rd_clr =
    (rd_acc & sel_irq) ? prdata[`STX_IRQ_W-1:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup & ~pready;
      pslverr <= setup & ~pready & ~sel_any;
      if (setup) begin
        prdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  wire addr_done = (state == stx_pkg::STX_ADDR) & scl_fall & (bit_cnt == 4'h8);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_slave_address <= `STX_RST_ADDR;
      irq_mask          <= 3'h0;
      deep_sleep        <= 1'b0;
    end else if (wr_acc) begin
      if (sel_addr) begin
        own_slave_address <= pwdata[7:0];
      end
      if (sel_mask) begin
        irq_mask <= pwdata[`STX_IRQ_W-1:0];
      end
      if (sel_mode) begin
        deep_sleep <= pwdata[`STX_MODE_SLEEP];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_control_register <= `STX_RST_CTRL;
    end else if (wr_ctrl) begin
      bus_control_register <= pwdata[7:0] & `STX_CTL_WMASK;
    end else begin
      if (hw_stop_clr) begin
        bus_control_register[`STX_CTL_STOP] <= 1'b0;
      end
      if (hw_start_clr) begin
        bus_control_register[`STX_CTL_START] <= 1'b0;
      end
    end
  end

  // The address byte is kept out of the data register when it arrives in
  // deep sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_data_register <= `STX_RST_DATA;
    end else if (wr_acc & sel_data) begin
      bus_data_register <= pwdata[7:0];
    end else if (addr_done & ~deep_sleep) begin
      bus_data_register <= shreg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address match

  wire own_hit = shreg[7:1] == own_slave_address[7:1];
  wire gc_hit  = (shreg[7:1] == `STX_GC_ADDR) &
                 own_slave_address[`STX_ADR_GCE];
  // No answer while ack enable is low, bus still tracked
  wire addr_hit = (own_hit | gc_hit) & acknowledge_enable;
  wire bad_pos  = ((state == stx_pkg::STX_ADDR) & (bit_cnt != 4'h0)) |
                  (state == stx_pkg::STX_ADDR_ACK) |
                  (state == stx_pkg::STX_TX) |
                  (state == stx_pkg::STX_TX_ACK);
  wire bus_err  = (start_det | stop_det) & bad_pos;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= stx_pkg::STX_IDLE;
      interrupt_flag <= 1'b0;
      status_code    <= `STX_CODE_NONE;
      shreg          <= 8'h00;
      bit_cnt        <= 4'h0;
      last_byte      <= 1'b0;
      master_ack     <= 1'b0;
      arb_pend       <= 1'b0;
      busy           <= 1'b0;
      start_pend     <= 1'b0;
      gen_cnt        <= 10'h000;
      tx_mode        <= 1'b0;
      rx_mode        <= 1'b0;
      scl_oe         <= 1'b0;
      sda_oe         <= 1'b0;
      wake_req       <= 1'b0;
      start_sent     <= 1'b0;
      hw_stop_clr    <= 1'b0;
      hw_start_clr   <= 1'b0;
    end else begin
      hw_stop_clr  <= 1'b0;
      hw_start_clr <= 1'b0;
      start_sent   <= 1'b0;
      if (flag_clr) begin
        interrupt_flag <= 1'b0;
      end
      if (arb_lost) begin
        arb_pend <= 1'b1;
      end
      if (start_det) begin
        busy <= 1'b1;
      end else if (stop_det) begin
        busy <= 1'b0;
      end
      if (!interface_enable) begin
        state  <= stx_pkg::STX_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_err) begin
        interrupt_flag <= 1'b1;
        status_code    <= `STX_CODE_BUS_ERR;
        state          <= stx_pkg::STX_HOLD;
        scl_oe         <= 1'b0;
        sda_oe         <= 1'b0;
      end else if (start_det & (state != stx_pkg::STX_GEN)) begin
        state   <= stx_pkg::STX_ADDR;
        bit_cnt <= 4'h0;
      end else if (stop_det & (state != stx_pkg::STX_HOLD)) begin
        state   <= stx_pkg::STX_IDLE;
        tx_mode <= 1'b0;
        rx_mode <= 1'b0;
      end else begin
        unique case (state)
          stx_pkg::STX_IDLE: begin
            // Wait for a free bus before sending the queued START
            if (start_pend & ~busy & scl_f & sda_f) begin
              state   <= stx_pkg::STX_GEN;
              gen_cnt <= 10'h000;
              sda_oe  <= 1'b1;
            end
          end
          stx_pkg::STX_GEN: begin
            gen_cnt <= gen_cnt + 10'h001;
            if (gen_cnt == HOLD_CYC - 10'h001) begin
              sda_oe       <= 1'b0;
              start_sent   <= 1'b1;
              start_pend   <= 1'b0;
              hw_start_clr <= 1'b1;
              state        <= stx_pkg::STX_IDLE;
            end
          end
          stx_pkg::STX_ADDR: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (addr_done) begin
              if (addr_hit & shreg[0]) begin
                state   <= stx_pkg::STX_ADDR_ACK;
                sda_oe  <= 1'b1;
                tx_mode <= 1'b1;
              end else if (addr_hit) begin
                // Receiving belongs to the receiver block
                state   <= stx_pkg::STX_IGNORE;
                rx_mode <= 1'b1;
              end else begin
                state <= stx_pkg::STX_IGNORE;
              end
            end
          end
          stx_pkg::STX_ADDR_ACK: begin
            if (scl_fall) begin
              sda_oe         <= 1'b0;
              scl_oe         <= 1'b1;
              interrupt_flag <= 1'b1;
              // Lost arbitration earlier changes the code
              status_code    <= arb_pend ? `STX_CODE_ARB_RD
                                         : `STX_CODE_ADDR_RD;
              arb_pend       <= 1'b0;
              wake_req       <= deep_sleep;
              state          <= stx_pkg::STX_HOLD;
            end
          end
          stx_pkg::STX_HOLD: begin
            // Clock stays low until software clears the flag, unless a bus error already released it
            if (!interrupt_flag) begin
              scl_oe   <= 1'b0;
              wake_req <= 1'b0;
              if ((status_code == `STX_CODE_ADDR_RD) |
                  (status_code == `STX_CODE_ARB_RD) |
                  (status_code == `STX_CODE_DATA_ACK)) begin
                shreg     <= bus_data_register;
                last_byte <= ~acknowledge_enable;
                sda_oe    <= ~bus_data_register[7];
                bit_cnt   <= 4'h0;
                state     <= stx_pkg::STX_TX;
              end else begin
                // Not addressed; START queued if asked, except after a bus error
                start_pend  <= start_request &
                               (status_code != `STX_CODE_BUS_ERR);
                hw_stop_clr <= status_code == `STX_CODE_BUS_ERR;
                tx_mode     <= 1'b0;
                sda_oe      <= 1'b0;
                state       <= stx_pkg::STX_IDLE;
              end
            end
          end
          stx_pkg::STX_TX: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h7) begin
                sda_oe <= 1'b0;
                state  <= stx_pkg::STX_TX_ACK;
              end else begin
                shreg  <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
              end
            end
          end
          stx_pkg::STX_TX_ACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_f;
            end else if (scl_fall) begin
              interrupt_flag <= 1'b1;
              scl_oe         <= 1'b1;
              state          <= stx_pkg::STX_HOLD;
              if (!master_ack) begin
                status_code <= `STX_CODE_NACK;
              end else if (last_byte) begin
                status_code <= `STX_CODE_LAST_ACK;
              end else begin
                status_code <= `STX_CODE_DATA_ACK;
              end
            end
          end
          stx_pkg::STX_IGNORE: begin
            // Data line stays released; a master reading sees ones
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output

  wire                  flag_evt = interrupt_flag & ~flag_q;
  wire                  berr_evt = flag_evt &
                                   (status_code == `STX_CODE_BUS_ERR);
  wire                  wake_evt = wake_req & ~wake_q;
  wire [`STX_IRQ_W-1:0] irq_evt  = {wake_evt, berr_evt, flag_evt};

  // A new event wins over a read clear in the same cycle
  wire [`STX_IRQ_W-1:0] next_irq_pend = (irq_pend & ~irq_rd_clr) | irq_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q   <= 1'b0;
      wake_q   <= 1'b0;
      irq_pend <= 3'h0;
      irq      <= 1'b0;
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
    end else begin
      flag_q   <= interrupt_flag;
      wake_q   <= wake_req;
      irq_pend <= next_irq_pend;
      irq      <= |(next_irq_pend & irq_mask);
    end
  end

endmodule

/* verif/stx_master_model.sv */
// Behavioural two-wire master receiver that pulls the lines open drain.
// Assumes pull-ups, so a released line reads high.
`timescale 1ns/1ps

module stx_master_model (
  // Resolved bus lines
  input  wire logic scl,
  input  wire logic sda,
  // Pulls, high while driving the line low
  output logic      scl_oe,
  output logic      sda_oe
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  // Waits out any clock stretching by the slave before sampling
  task automatic bit_io(input logic b, output logic got);
    #40 sda_oe = ~b;
    #40 scl_oe = 1'b0;
    wait (scl);
    #40 got = sda;
    #40 scl_oe = 1'b1;
  endtask

  task automatic start_c();
    #40 sda_oe = 1'b1;
    #40 scl_oe = 1'b1;
  endtask

  task automatic stop_c();
    #40 sda_oe = 1'b1;
    #40 scl_oe = 1'b0;
    wait (scl);
    #40 sda_oe = 1'b0;
    #40;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(b[i], g);
    bit_io(1'b1, g);
    ack = ~g;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(~ack, g);
  endtask
endmodule

/* verif/stx_checker.sv */
// Port-level checks of the slave transmitter.
// Bound into every stx_top; sees its ports only.
`timescale 1ns/1ps
`include "stx_consts.svh"

module stx_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Bus pins and system
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        wake_req,
  input wire logic        start_sent
);
  localparam int HOLD_MIN = `STX_START_HOLD_CYC - 10;
  wire logic   setup;
  logic [11:0] run_len;
  logic [11:0] last_len;

  assign setup = psel && !penable;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Keeps the last nonzero run so a late start pulse still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_len  <= 12'h000;
      last_len <= 12'h000;
    end else if (sda_oe && !scl_oe) begin
      run_len <= run_len + 12'h001;
    end else begin
      run_len  <= 12'h000;
      last_len <= (run_len != 12'h000) ? run_len : last_len;
    end
  end

  a_ready_after_setup: assert property (setup |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property
    (setup && paddr > `STX_OFF_MODE |=> pslverr)
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (setup && paddr <= `STX_OFF_MODE
    && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  a_status_form: assert property
    (setup && !pwrite && paddr == `STX_OFF_STAT
    |=> prdata[2:0] == 3'h0 && prdata[31:8] == 24'h0)
    else $error("status prescaler bits not zero");
  a_pins_open_drain: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  a_start_pulse: assert property (start_sent |=> !start_sent)
    else $error("start_sent longer than one cycle");
  a_start_hold: assert property (start_sent |-> scl_i
    && (run_len >= HOLD_MIN || last_len >= HOLD_MIN))
    else $error("start condition too short");
  a_wake_holds_scl: assert property
    (wake_req && scl_oe |=> scl_oe || !wake_req)
    else $error("clock released during wake");
endmodule

bind stx_top stx_checker i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_o(sda_o), .sda_oe(sda_oe), .wake_req(wake_req),
  .start_sent(start_sent)
);

/* verif/test_twi_slave_transmitter.sv */
// Bench: APB software thread against a master receiver model.
// Assumes wired-AND bus lines with pull-ups.
`timescale 1ns/1ps
`include "stx_consts.svh"

module test_twi_slave_transmitter;
  logic        pclk, presetn, psel, penable, pwrite, arb_lost;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe;
  logic        irq, wake_req, start_sent, m_scl_oe, m_sda_oe;
  logic        last_err, m_ack;
  wire logic   scl_ln, sda_ln;
  int          n_mismatch = 0;
  int          checked = 0;
  int          wk;

  assign scl_ln = ~(scl_oe | m_scl_oe);
  assign sda_ln = ~(sda_oe | m_sda_oe);

  stx_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl_ln), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_ln), .sda_o(sda_o), .sda_oe(sda_oe),
    .arb_lost(arb_lost), .irq(irq), .wake_req(wake_req),
    .start_sent(start_sent)
  );
  stx_master_model i_master (
    .scl(scl_ln), .sda(sda_ln), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until pready is sampled high at a rising edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v     = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, rd_v, e);
  endtask

  task automatic send(input logic [7:0] d, c);
    wr(`STX_OFF_DATA, d);
    wr(`STX_OFF_CTRL, c);
  endtask

  task automatic sw_wait(input logic [7:0] code);
    int k;
    k = 0;
    do begin
      apb(1'b0, `STX_OFF_CTRL, 8'h00);
      k++;
    end while (rd_v[7] !== 1'b1 && k < 3000);
    apb(1'b0, `STX_OFF_STAT, 8'h00);
    chk("status", rd_v & 32'hF8, {24'h0, code});
  endtask

  task automatic xfer(input logic [7:0] adr, input int n,
                      input logic [31:0] exp, input logic ack_e);
    logic       ack;
    logic [7:0] b;
    i_master.start_c();
    i_master.send_byte(adr, ack);
    chk("addr_ack", {31'h0, ack}, {31'h0, ack_e});
    for (int i = 0; i < n; i++) begin
      i_master.recv_byte(i < n - 1, b);
      chk("rx_byte", {24'h0, b}, {24'h0, exp[31 - 8 * i -: 8]});
    end
    i_master.stop_c();
  endtask

  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end

  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    arb_lost = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`STX_OFF_ADDR, 32'h0, "addr_rst");
    rd(`STX_OFF_CTRL, 32'h0, "ctrl_rst");
    rd(`STX_OFF_STAT, 32'hF8, "stat_rst");
    rd(`STX_OFF_DATA, 32'hFF, "data_rst");
    rd(`STX_OFF_MASK, 32'h0, "mask_rst");
    rd(8'h1C, 32'h0, "unmapped_data");
    chk("unmapped_err", {31'h0, last_err}, 32'h1);
    wr(`STX_OFF_ADDR, 8'hB4);
    wr(`STX_OFF_MASK, 8'h07);
    wr(`STX_OFF_CTRL, 8'h04);
    rd(`STX_OFF_ADDR, 32'hB4, "addr_rw");
    xfer(8'hB5, 0, 32'h0, 1'b0);
    wr(`STX_OFF_CTRL, 8'h44);
    xfer(8'hB7, 0, 32'h0, 1'b0);
    xfer(8'h01, 0, 32'h0, 1'b0);
    i_master.start_c();
    i_master.send_byte(8'hB4, m_ack);
    chk("rx_nack", {31'h0, m_ack}, 32'h0);
    rd(`STX_OFF_MODE, 32'h4, "mode_rx");
    i_master.stop_c();
    fork
      xfer(8'hB5, 3, 32'h963CA500, 1'b1);
      begin
        sw_wait(8'hA8);
        chk("irq", {31'h0, irq}, 32'h1);
        chk("scl_hold", {31'h0, scl_oe}, 32'h1);
        rd(`STX_OFF_MODE, 32'h2, "mode_tx");
        rd(`STX_OFF_IRQ, 32'h1, "irq_stat");
        repeat (2) @(negedge pclk);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        send(8'h96, 8'hC4);
        sw_wait(8'hB8);
        send(8'h3C, 8'hC4);
        sw_wait(8'hB8);
        send(8'hA5, 8'h84);
        sw_wait(8'hC0);
        wr(`STX_OFF_CTRL, 8'hC4);
        rd(`STX_OFF_STAT, 32'hF8, "stat_idle");
      end
    join
    wr(`STX_OFF_MASK, 8'h00);
    arb_lost <= 1'b1;
    @(posedge pclk);
    arb_lost <= 1'b0;
    fork
      xfer(8'hB5, 2, 32'h5CFF0000, 1'b1);
      begin
        sw_wait(8'hB0);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        send(8'h5C, 8'h84);
        sw_wait(8'hC8);
        wr(`STX_OFF_CTRL, 8'hE4);
      end
    join
    wk = 0;
    while (start_sent !== 1'b1 && wk < 3000) begin
      @(negedge pclk);
      wk++;
    end
    chk("start_sent", {31'h0, start_sent}, 32'h1);
    rd(`STX_OFF_CTRL, 32'h44, "start_req_clr");
    wr(`STX_OFF_ADDR, 8'hB5);
    wr(`STX_OFF_MODE, 8'h01);
    fork
      begin
        i_master.start_c();
        i_master.send_byte(8'h01, m_ack);
        chk("gc_ack", {31'h0, m_ack}, 32'h1);
        repeat (3) i_master.bit_io(1'b1, m_ack);
        i_master.stop_c();
      end
      begin
        sw_wait(8'hA8);
        chk("wake", {31'h0, wake_req & scl_oe}, 32'h1);
        rd(`STX_OFF_IRQ, 32'h5, "irq_wake");
        rd(`STX_OFF_DATA, 32'h5C, "data_sleep");
        wr(`STX_OFF_MODE, 8'h00);
        send(8'hFF, 8'hC4);
        repeat (2) @(negedge pclk);
        chk("wake_clr", {31'h0, wake_req}, 32'h0);
        sw_wait(8'h00);
        chk("err_free", {30'h0, scl_oe, sda_oe}, 32'h0);
        wr(`STX_OFF_CTRL, 8'hD4);
        // Hardware clears the stop request two cycles after the flag
        repeat (2) @(posedge pclk);
        rd(`STX_OFF_CTRL, 32'h44, "stop_clr");
      end
    join
    rd(`STX_OFF_IRQ, 32'h3, "irq_berr");
    final_report();
  end
endmodule
